/* rtl/ibe_engine.sv */
// Two-wire bus engine: master and slave roles, bus monitor, result buffer
`timescale 1ns/1ps
module ibe_engine (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Bus pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Master commands
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_start,
  input wire logic cmd_stop,
  input wire logic cmd_read,
  input wire logic [7:0] cmd_data,
  // Slave setup and transmit data
  input wire logic slv_en,
  input wire logic gc_en,
  input wire logic [6:0] own_addr,
  input wire logic slv_tx_valid,
  output logic slv_tx_ready,
  input wire logic [7:0] slv_tx_data,
  // Results
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [ibe_pkg::RX_W-1:0] rx_data,
  // Status
  output logic arb_lost,
  input wire logic arb_clr,
  output logic bus_busy,
  output logic slv_sel
);
  // ----------------------------------------
  // Line sampling and bus monitor
  // ----------------------------------------
  logic scl_m_q, scl_s_q, scl_p_q;
  logic sda_m_q, sda_s_q, sda_p_q;
  logic bus_busy_q;
  logic [ibe_pkg::CNT_W-1:0] free_q;
  logic scl_rise, scl_fall, start_det, stop_det, bus_free;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_m_q <= scl_in;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_in;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  assign scl_rise = scl_s_q & ~scl_p_q;
  assign scl_fall = ~scl_s_q & scl_p_q;
  assign start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop_det = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus_busy_q <= 1'b0;
    end else if (start_det) begin
      bus_busy_q <= 1'b1;
    end else if (stop_det) begin
      bus_busy_q <= 1'b0;
    end
  end

  // Both lines must rest high a full free time before a new start
  always_ff @(posedge ref_clk) begin
    if (rst || bus_busy_q || !scl_s_q || !sda_s_q) begin
      free_q <= '0;
    end else if (!bus_free) begin
      free_q <= free_q + 1'b1;
    end
  end
  assign bus_free = free_q == ibe_pkg::CNT_W'(ibe_pkg::FREE_CYC);

  // ----------------------------------------
  // Result buffer
  // ----------------------------------------
  logic [ibe_pkg::RX_W-1:0] mem_q [2];
  logic wp_q, rp_q;
  logic [1:0] fill_q;
  logic push_req, push_slv, push_nack, buf_rdy, push, pop;
  logic [7:0] push_byte;

  assign buf_rdy = fill_q != ibe_pkg::BUF_DEPTH;
  assign push = push_req & buf_rdy;
  assign pop = rx_valid & rx_ready;
  assign rx_valid = fill_q != 2'h0;
  assign rx_data = mem_q[rp_q];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      fill_q <= 2'h0;
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end else begin
      if (push) begin
        mem_q[wp_q] <= {push_slv, push_nack, push_byte};
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      fill_q <= fill_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // ----------------------------------------
  // Master
  // ----------------------------------------
  ibe_pkg::ibe_mst_t m_st_q;
  logic [ibe_pkg::CNT_W-1:0] cnt_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic m_scl_oe_q, m_sda_oe_q, own_q, rd_q, nack_q, arb_q;
  logic half_done;

  assign half_done = cnt_q == ibe_pkg::CNT_W'(ibe_pkg::HALF_CYC - 1);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      arb_q <= 1'b0;
    end else if (m_st_q == ibe_pkg::M_HIGH && cnt_q == '0 && scl_s_q && bit_q < ibe_pkg::ACK_SLOT
                 && !rd_q && !m_sda_oe_q && !sda_s_q) begin
      arb_q <= 1'b1;
    end else if (arb_clr) begin
      arb_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      m_st_q <= ibe_pkg::M_IDLE;
      cnt_q <= '0;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      m_scl_oe_q <= 1'b0;
      m_sda_oe_q <= 1'b0;
      own_q <= 1'b0;
      rd_q <= 1'b0;
      nack_q <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      unique case (m_st_q)
        ibe_pkg::M_IDLE: begin
          cnt_q <= '0;
          if (cmd_valid && !slv_sel && !arb_q) begin
            rd_q <= cmd_read;
            sh_q <= cmd_data;
            bit_q <= 4'h0;
            if (cmd_start || !own_q) begin
              m_st_q <= own_q ? ibe_pkg::M_RS : ibe_pkg::M_FREE;
            end else begin
              m_st_q <= ibe_pkg::M_LOW;
            end
          end
        end
        ibe_pkg::M_FREE: begin
          cnt_q <= '0;
          if (bus_free) begin
            m_sda_oe_q <= 1'b1;
            m_st_q <= ibe_pkg::M_START;
          end
        end
        ibe_pkg::M_RS: begin
          m_sda_oe_q <= 1'b0;
          if (half_done) begin
            m_scl_oe_q <= 1'b0;
            cnt_q <= '0;
            m_st_q <= ibe_pkg::M_RSH;
          end
        end
        ibe_pkg::M_RSH: begin
          if (!scl_s_q) begin
            cnt_q <= '0;
          end else if (half_done) begin
            m_sda_oe_q <= 1'b1;
            cnt_q <= '0;
            m_st_q <= ibe_pkg::M_START;
          end
        end
        ibe_pkg::M_START: begin
          if (half_done) begin
            m_scl_oe_q <= 1'b1;
            own_q <= 1'b1;
            cnt_q <= '0;
            m_st_q <= ibe_pkg::M_LOW;
          end
        end
        ibe_pkg::M_LOW: begin
          // Data moves only here, with the clock pulled low
          if (cnt_q == '0) begin
            if (bit_q < ibe_pkg::ACK_SLOT) begin
              m_sda_oe_q <= !rd_q && !sh_q[7];
            end else begin
              m_sda_oe_q <= rd_q && !cmd_stop;
            end
          end
          if (half_done) begin
            m_scl_oe_q <= 1'b0;
            cnt_q <= '0;
            m_st_q <= ibe_pkg::M_HIGH;
          end
        end
        ibe_pkg::M_HIGH: begin
          if (!scl_s_q) begin
            cnt_q <= '0;
          end else begin
            if (cnt_q == '0 && bit_q < ibe_pkg::ACK_SLOT) begin
              sh_q <= {sh_q[6:0], sda_s_q};
              if (!rd_q && !m_sda_oe_q && !sda_s_q) begin
                // Released bit read back low: another master owns the bus
                m_scl_oe_q <= 1'b0;
                own_q <= 1'b0;
                m_st_q <= ibe_pkg::M_IDLE;
              end
            end else if (cnt_q == '0) begin
              nack_q <= sda_s_q;
            end
            if (half_done && m_st_q == ibe_pkg::M_HIGH) begin
              m_scl_oe_q <= 1'b1;
              cnt_q <= '0;
              if (bit_q == ibe_pkg::ACK_SLOT) begin
                m_st_q <= ibe_pkg::M_DONE;
              end else begin
                bit_q <= bit_q + 1'b1;
                m_st_q <= ibe_pkg::M_LOW;
              end
            end
          end
        end
        ibe_pkg::M_DONE: begin
          cnt_q <= '0;
          m_sda_oe_q <= 1'b0;
          if (buf_rdy) begin
            m_sda_oe_q <= cmd_stop;
            m_st_q <= cmd_stop ? ibe_pkg::M_P1 : ibe_pkg::M_IDLE;
          end
        end
        ibe_pkg::M_P1: begin
          if (half_done) begin
            m_scl_oe_q <= 1'b0;
            cnt_q <= '0;
            m_st_q <= ibe_pkg::M_P2;
          end
        end
        ibe_pkg::M_P2: begin
          if (!scl_s_q) begin
            cnt_q <= '0;
          end else if (half_done) begin
            m_sda_oe_q <= 1'b0;
            own_q <= 1'b0;
            m_st_q <= ibe_pkg::M_IDLE;
          end
        end
      endcase
    end
  end

  assign cmd_ready = m_st_q == ibe_pkg::M_DONE && buf_rdy;

  // ----------------------------------------
  // Slave
  // ----------------------------------------
  ibe_pkg::ibe_slv_t s_st_q;
  logic [3:0] sb_q;
  logic [7:0] ssh_q, stx_q;
  logic s_scl_oe_q, s_sda_oe_q, adr_ph_q, rw_q, snack_q;
  logic hit;

  // Own addresses in reserved groups never match, so extended addressing is simply ignored
  function automatic logic addr_hit(input logic [7:0] b, input logic [6:0] a, input logic gc);
    logic rsv;
    rsv = a[6:3] == ibe_pkg::RSV_LO_GRP || a[6:3] == ibe_pkg::RSV_HI_GRP;
    return (b[7:1] == a && !rsv) || (b[7:1] == ibe_pkg::GEN_CALL_ADDR && gc && !b[0]);
  endfunction
  assign hit = addr_hit(ssh_q, own_addr, gc_en);

  always_ff @(posedge ref_clk) begin
    if (rst || stop_det) begin
      s_st_q <= ibe_pkg::S_IDLE;
      sb_q <= 4'h0;
      ssh_q <= 8'h00;
      stx_q <= 8'h00;
      s_scl_oe_q <= 1'b0;
      s_sda_oe_q <= 1'b0;
      adr_ph_q <= 1'b0;
      rw_q <= 1'b0;
      snack_q <= 1'b0;
    end else if (start_det) begin
      s_sda_oe_q <= 1'b0;
      s_scl_oe_q <= 1'b0;
      sb_q <= 4'h0;
      adr_ph_q <= 1'b1;
      rw_q <= 1'b0;
      s_st_q <= (slv_en && m_st_q == ibe_pkg::M_IDLE && !own_q) ? ibe_pkg::S_SHIFT : ibe_pkg::S_IDLE;
    end else begin
      unique case (s_st_q)
        ibe_pkg::S_IDLE: begin
          s_scl_oe_q <= 1'b0;
          s_sda_oe_q <= 1'b0;
        end
        ibe_pkg::S_SHIFT: begin
          if (scl_rise) begin
            ssh_q <= {ssh_q[6:0], sda_s_q};
            sb_q <= sb_q + 1'b1;
          end else if (scl_fall && sb_q == ibe_pkg::ACK_SLOT) begin
            s_sda_oe_q <= 1'b0;
            if (adr_ph_q) begin
              rw_q <= ssh_q[0];
              s_sda_oe_q <= hit;
              s_st_q <= hit ? ibe_pkg::S_ACK : ibe_pkg::S_IDLE;
            end else if (!rw_q) begin
              s_scl_oe_q <= 1'b1;
              s_st_q <= ibe_pkg::S_PUSH;
            end else begin
              s_st_q <= ibe_pkg::S_ACK;
            end
          end else if (scl_fall && rw_q && !adr_ph_q) begin
            stx_q <= {stx_q[6:0], 1'b0};
            s_sda_oe_q <= !stx_q[6];
          end else if (s_scl_oe_q) begin
            // First data bit stood a cycle on the line, now let the clock go
            s_scl_oe_q <= 1'b0;
          end
        end
        ibe_pkg::S_PUSH: begin
          // Full buffer keeps the clock held low so no byte is lost
          if (buf_rdy) begin
            s_sda_oe_q <= 1'b1;
            s_st_q <= ibe_pkg::S_ACK;
          end
        end
        ibe_pkg::S_ACK: begin
          if (scl_rise) begin
            snack_q <= sda_s_q;
          end else if (scl_fall) begin
            s_sda_oe_q <= 1'b0;
            sb_q <= 4'h0;
            adr_ph_q <= 1'b0;
            if (!rw_q) begin
              s_st_q <= ibe_pkg::S_SHIFT;
            end else if (!adr_ph_q && snack_q) begin
              s_st_q <= ibe_pkg::S_IDLE;
            end else begin
              s_scl_oe_q <= 1'b1;
              s_st_q <= ibe_pkg::S_LOAD;
            end
          end else if (s_scl_oe_q) begin
            // Ack settles before the held clock rises, never together with it
            s_scl_oe_q <= 1'b0;
          end
        end
        ibe_pkg::S_LOAD: begin
          if (slv_tx_valid) begin
            stx_q <= slv_tx_data;
            s_sda_oe_q <= !slv_tx_data[7];
            s_st_q <= ibe_pkg::S_SHIFT;
          end
        end
      endcase
    end
  end

  assign slv_tx_ready = s_st_q == ibe_pkg::S_LOAD && slv_tx_valid && !start_det && !stop_det;

  // ----------------------------------------
  // Pins and result selection
  // ----------------------------------------
  assign push_slv = s_st_q == ibe_pkg::S_PUSH;
  assign push_req = push_slv || m_st_q == ibe_pkg::M_DONE;
  assign push_nack = push_slv ? 1'b0 : (rd_q ? cmd_stop : nack_q);
  assign push_byte = push_slv ? ssh_q : sh_q;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = m_scl_oe_q | s_scl_oe_q;
  assign sda_oe = m_sda_oe_q | s_sda_oe_q;
  assign arb_lost = arb_q;
  assign bus_busy = bus_busy_q;
  assign slv_sel = s_st_q != ibe_pkg::S_IDLE && !adr_ph_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_start_cond;
    m_st_q == ibe_pkg::M_FREE && bus_free |=> m_sda_oe_q && !m_scl_oe_q;
  endproperty
  a_start_cond: assert property (p_start_cond) else $error("start not driven");

  property p_wait_free;
    m_st_q == ibe_pkg::M_FREE && !bus_free |=> !m_sda_oe_q && m_st_q == ibe_pkg::M_FREE;
  endproperty
  a_wait_free: assert property (p_wait_free) else $error("start on busy bus");

  property p_ack_release;
    m_st_q == ibe_pkg::M_LOW && bit_q == ibe_pkg::ACK_SLOT && !rd_q ##1 m_st_q == ibe_pkg::M_LOW |-> !m_sda_oe_q;
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("data held in ack slot");

  property p_hold_low;
    m_st_q == ibe_pkg::M_DONE |-> m_scl_oe_q && !bus_free;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("clock released before byte");

  property p_stretch;
    m_st_q == ibe_pkg::M_HIGH && !scl_s_q |=> m_st_q == ibe_pkg::M_HIGH && cnt_q == '0 && !m_scl_oe_q;
  endproperty
  a_stretch: assert property (p_stretch) else $error("clock advanced while held");

  property p_arb;
    m_st_q == ibe_pkg::M_HIGH && cnt_q == '0 && scl_s_q && bit_q < ibe_pkg::ACK_SLOT && !rd_q && !m_sda_oe_q && !sda_s_q
    |=> arb_q && !m_scl_oe_q && !m_sda_oe_q && m_st_q == ibe_pkg::M_IDLE;
  endproperty
  a_arb: assert property (p_arb) else $error("arbitration loss missed");

  property p_busy;
    start_det |=> bus_busy_q [*2];
  endproperty
  a_busy: assert property (p_busy) else $error("busy not set by start");

  property p_sda_stable;
    m_st_q == ibe_pkg::M_HIGH |=> $stable(m_sda_oe_q);
  endproperty
  a_sda_stable: assert property (p_sda_stable) else $error("data moved with clock high");

  property p_slave_ack;
    s_st_q == ibe_pkg::S_SHIFT && adr_ph_q && scl_fall && sb_q == ibe_pkg::ACK_SLOT && hit && !start_det && !stop_det
    |=> s_sda_oe_q && s_st_q == ibe_pkg::S_ACK;
  endproperty
  a_slave_ack: assert property (p_slave_ack) else $error("own address not acknowledged");
endmodule

/* rtl/ibe_pkg.sv */
// Constants and types of the two-wire bus protocol engine
package ibe_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_HALF_NS = 5000;
  localparam int T_FREE_NS = 4700;
  localparam int HALF_CYC = (T_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FREE_CYC = (T_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 11;
  // ----------------------------------------
  // Byte framing and addresses
  // ----------------------------------------
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
  localparam logic [3:0] RSV_LO_GRP = 4'h0;
  localparam logic [3:0] RSV_HI_GRP = 4'hf;
  // ----------------------------------------
  // Result word layout
  // ----------------------------------------
  localparam int RX_W = 10;
  localparam int RX_SLV_BIT = 9;
  localparam int RX_NACK_BIT = 8;
  localparam logic [1:0] BUF_DEPTH = 2'h2;
  // ----------------------------------------
  // States
  // ----------------------------------------
  typedef enum logic [3:0] {
    M_IDLE, M_FREE, M_START, M_RS, M_RSH,
    M_LOW, M_HIGH, M_DONE, M_P1, M_P2
  } ibe_mst_t;
  typedef enum logic [2:0] {
    S_IDLE, S_SHIFT, S_PUSH, S_ACK, S_LOAD
  } ibe_slv_t;
endpackage

/* testbench/ibe_bus_peer.sv */
// Behavioural far-side party: addressed slave, competing master and second master
`timescale 1ns/1ps
module ibe_bus_peer #(
  parameter logic [6:0] SLV_ADDR = 7'h50
) (
  // Wire levels
  input wire logic scl,
  input wire logic sda,
  // Open-drain pulls, high = line driven low
  output logic scl_pull,
  output logic sda_pull
);
  logic fight = 1'b0;
  logic mst_busy = 1'b0;
  int stretch_ns = 0;
  int viol = 0;
  logic [7:0] got_q[$];

  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end

  // ----------------------------------------
  // Slave side
  // ----------------------------------------
  // A data change while the clock is high ends the bit early
  task automatic get_bit(output logic b, output logic cond);
    @(posedge scl);
    b = sda;
    @(negedge scl or sda);
    cond = scl;
  endtask

  task automatic slave_frame();
    logic b;
    logic cond;
    logic first;
    logic [7:0] v;
    first = 1'b1;
    if (fight) begin
      // Acts as a rival master whose first bit is low
      sda_pull = 1'b1;
      @(posedge scl);
      #200 scl_pull = 1'b1;
      #1000 scl_pull = 1'b0;
      #1000 sda_pull = 1'b0;
      return;
    end
    forever begin
      for (int i = 7; i >= 0; i--) begin
        get_bit(b, cond);
        if (cond) begin
          if (i != 7) viol++;
          return;
        end
        v[i] = b;
      end
      if (first && v[7:1] != SLV_ADDR) return;
      if (!first) got_q.push_back(v);
      first = 1'b0;
      sda_pull = 1'b1;
      get_bit(b, cond);
      sda_pull = 1'b0;
      if (stretch_ns > 0) begin
        scl_pull = 1'b1;
        #(stretch_ns) scl_pull = 1'b0;
      end
    end
  endtask

  always begin
    @(negedge sda);
    if (scl === 1'b1 && !mst_busy) slave_frame();
  end

  // ----------------------------------------
  // Master side, 48 ns link clock only inside frames
  // ----------------------------------------
  task automatic wr_frame(input logic [7:0] q[$], output logic [7:0] nak);
    nak = 8'hff;
    wait (scl === 1'b1 && sda === 1'b1);
    mst_busy = 1'b1;
    sda_pull = 1'b1;
    #24 scl_pull = 1'b1;
    foreach (q[k]) begin
      for (int i = 8; i >= 0; i--) begin
        #4 sda_pull = (i > 0) ? ~q[k][i-1] : 1'b0;
        #20 scl_pull = 1'b0;
        wait (scl === 1'b1);
        if (i == 0) nak[k] = sda;
        #24 scl_pull = 1'b1;
      end
    end
    #4 sda_pull = 1'b1;
    #20 scl_pull = 1'b0;
    wait (scl === 1'b1);
    #24 sda_pull = 1'b0;
    #24 mst_busy = 1'b0;
  endtask
endmodule

/* testbench/tb_top.sv */
// Self-checking bench of the two-wire bus engine against a behavioural peer
`timescale 1ns/1ps
module tb_top;
  logic ref_clk, rst, scl_oe, sda_oe, p_scl, p_sda;
  logic cmd_valid, cmd_ready, cmd_start, cmd_stop, rx_valid, rx_ready;
  logic arb_lost, arb_clr, bus_busy, slv_sel;
  logic [7:0] cmd_data, nak, d1;
  logic [6:0] own_addr;
  logic [9:0] rx_data, exp_w;
  logic [9:0] exp_q[$];
  logic [7:0] fq[$];
  integer seed = 32'h8325;
  int n_fail = 0, checks_done = 0, cyc = 0, w;
  // Pull-ups: a line is high unless some party pulls it
  wire scl = (scl_oe === 1'b1 || p_scl === 1'b1) ? 1'b0 : 1'b1;
  wire sda = (sda_oe === 1'b1 || p_sda === 1'b1) ? 1'b0 : 1'b1;

  ibe_engine u_dut (
    .ref_clk(ref_clk), .rst(rst),
    .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_start(cmd_start), .cmd_stop(cmd_stop),
    .cmd_read(1'b0), .cmd_data(cmd_data),
    .slv_en(1'b1), .gc_en(1'b1), .own_addr(own_addr),
    .slv_tx_valid(1'b0), .slv_tx_ready(), .slv_tx_data(8'h00),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .arb_lost(arb_lost), .arb_clr(arb_clr), .bus_busy(bus_busy), .slv_sel(slv_sel)
  );

  ibe_bus_peer u_peer (.scl(scl), .sda(sda), .scl_pull(p_scl), .sda_pull(p_sda));

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic send_cmd(input logic st, input logic sp, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_start = st;
    cmd_stop = sp;
    cmd_data = d;
    exp_q.push_back({2'h0, d});
    do begin
      @(posedge ref_clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 90000);
    @(negedge ref_clk);
    cmd_valid = 1'b0;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (bus_busy !== 1'b0 && n < 5000) begin
      @(negedge ref_clk);
      n++;
    end
  endtask

  // Results are compared in order against the notes left by the drivers
  always @(posedge ref_clk) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      exp_w = (exp_q.size() > 0) ? exp_q.pop_front() : 10'hx;
      check("rx_data", rx_data, exp_w);
    end
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 100000) begin
      n_fail++;
      end_of_test();
    end
  end

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_start = 1'b0;
    cmd_stop = 1'b0;
    cmd_data = 8'h00;
    rx_ready = 1'b1;
    arb_clr = 1'b0;
    own_addr = 7'h3a;
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    // Rival master wins the first bit, then the command retries
    u_peer.fight = 1'b1;
    u_peer.stretch_ns = 2000;
    fork
      send_cmd(1'b1, 1'b0, 8'ha0);
      begin
        w = 0;
        while (arb_lost !== 1'b1 && w < 20000) begin
          @(negedge ref_clk);
          w++;
        end
        repeat (4) @(negedge ref_clk);
        check("lost", {arb_lost, bus_busy, sda_oe, scl_oe}, 4'hc);
        u_peer.fight = 1'b0;
        wait_idle();
        check("lost_idle", {arb_lost, bus_busy}, 2'h2);
        arb_clr = 1'b1;
        @(negedge ref_clk);
        arb_clr = 1'b0;
        @(negedge ref_clk);
        check("arb_clr", arb_lost, 1'b0);
      end
    join
    // Clock held low while the next byte is not ready
    // Long enough that the peer's own stretch has ended
    repeat (600) @(negedge ref_clk);
    check("scl_hold", {scl, scl_oe, bus_busy}, 3'h3);
    d1 = $random(seed);
    send_cmd(1'b0, 1'b1, d1);
    wait_idle();
    check("stop", {bus_busy, scl_oe, sda_oe, scl, sda}, 5'h03);
    check("peer_n", u_peer.got_q.size(), 10'h1);
    check("peer_byte", u_peer.got_q.pop_front(), d1);
    check("viol", u_peer.viol, 10'h0);
    u_peer.stretch_ns = 0;
    // Foreign address is ignored
    fq = {8'h76};
    u_peer.wr_frame(fq, nak);
    check("nak_other", {nak[0], slv_sel}, 2'h2);
    // Own address with three bytes while the consumer stalls
    @(negedge ref_clk);
    rx_ready = 1'b0;
    fq = {8'h74};
    repeat (3) begin
      d1 = $random(seed);
      fq.push_back(d1);
      exp_q.push_back({2'h2, d1});
    end
    fork
      u_peer.wr_frame(fq, nak);
      begin
        repeat (900) @(negedge ref_clk);
        check("stall", {slv_sel, bus_busy, rx_valid, scl}, 4'he);
        rx_ready = 1'b1;
      end
    join
    check("nak_own", nak[3:0], 4'h0);
    // General call then one byte
    d1 = $random(seed);
    fq = {8'h00, d1};
    exp_q.push_back({2'h2, d1});
    u_peer.wr_frame(fq, nak);
    check("nak_gc", nak[1:0], 2'h0);
    wait_idle();
    repeat (20) @(negedge ref_clk);
    check("end", {bus_busy, slv_sel, rx_valid}, 3'h0);
    check("left", exp_q.size(), 10'h0);
    end_of_test();
  end
endmodule
